// file: hdl/wake_timer_defines.svh
/*
 wake timer constants: register indices, reset values, timing figures.
 assumes inclusion by bare name from design files.
*/
`ifndef WAKE_TIMER_DEFINES_SVH
`define WAKE_TIMER_DEFINES_SVH
// ---------------------------------------------------------
// register map
// ---------------------------------------------------------
`define REG_CONFIG 4'h0
`define REG_MULT_HI 4'h1
`define REG_MULT_LO 4'h2
`define REG_EXP_STATE 4'h3
`define REG_DUTY_COUNT 4'h4
`define REG_INT_STATUS 4'h5
`define REG_INT_CLEAR 4'h6
`define REG_INT_ENABLE 4'h7
`define REG_CLK_CFG 4'h8
`define REG_DEV_STATE 4'h9
`define REG_RESET_VAL 8'h00
`define READ_NONE 8'h00
// ---------------------------------------------------------
// fields and encodings
// ---------------------------------------------------------
`define INT_WAKE_BIT 0
`define INT_CAL_BIT 1
`define CLK_SEL_BIT 0
`define DC_OFF 2'h0
`define DC_RX 2'h1
`define DC_TX 2'h2
`define PERIOD_SCALE_SHIFT 2
`define PRE_ONE 34'h1
// ---------------------------------------------------------
// timing
// ---------------------------------------------------------
`define RC_FREQ_HZ 32768
`define XO_FREQ_HZ 30000000
`define CAL_RC_TICKS 32
`define CAL_XO_EXPECT ((`XO_FREQ_HZ / `RC_FREQ_HZ) * `CAL_RC_TICKS)
`define CAL_BASE_SHIFT 14
`endif

// file: hdl/wake_timer_pkg.sv
/*
 wake timer types: configuration bytes and state encodings.
 assumes the defines header is not needed here.
*/
package wake_timer_pkg;
   typedef struct packed {
      logic [2:0] rcRecalInterval;
      logic calEnable;
      logic [1:0] dutyCycleModeSelect;
      logic batteryCheckOnInterval;
      logic timerRunEnable;
   } wake_cfg_t;
   typedef struct packed {
      logic [1:0] spare;
      logic afterExpiryStateSelect;
      logic [4:0] periodExponent;
   } exp_state_t;
   typedef enum logic [2:0] {
      PS_READY = 3'h1,
      PS_SLEEP = 3'h2,
      PS_ACTIVE = 3'h4
   } power_state_t;
   typedef enum logic [3:0] {
      CAL_IDLE = 4'h1,
      CAL_XO_START = 4'h2,
      CAL_MEASURE = 4'h4,
      CAL_ADJUST = 4'h8
   } cal_state_t;
endpackage

// file: hdl/periodic_wakeup_timer.sv
/*
 periodic wake timer with rc recalibration, duty-cycle window and
 chip interrupt. assumes 32 kHz tick strobes and the 30 MHz crystal
 tick strobe arrive synchronous to clk, one cycle wide.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wake_timer_defines.svh"
// Function
// RL1 - wake period equals multiplier times 4 times 2^exponent ticks.
// RL2 - with the run enable set the period keeps counting during sleep.
// RL3 - expiry drives the active-low interrupt only when enabled.
// RL4 - the host confirms the cause by reading interrupt status.
// RL5 - ticks come from the rc oscillator or the 32 kHz crystal.
// RL6 - rc calibration runs on power-up and on shutdown exit.
// RL7 - periodic recalibration needs its enable, interval by a 3-bit field.
// RL8 - calibration starts the crystal, compares, then trims the rc.
// RL9 - duty mode 0 none, 1 receive start, 2 transmit start at wake.
// RL10 - after expiry go to ready when select is 0, sleep when 1.
// RL11 - multiplier is loaded from a high byte and a low byte.
// RL12 - exponent is 5 bits sharing a byte with the state select.
// RL13 - battery check runs at each interval when enabled.
// RL14 - duty count is a separate byte apart from the period fields.
// RL15 - duty window equals count times 4 times 2^exponent ticks.
// RL16 - each expiry reloads and starts the next period at once.
module periodic_wakeup_timer
#(
   parameter int TRIM_W = 7,
   parameter int RECAL_W = 24
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wrEn,
   input wire logic rdEn,
   output logic [7:0] rdata,
   // clock sources
   input wire logic rcTick,
   input wire logic xtalTick,
   input wire logic xoTick,
   input wire logic xoReady,
   output logic xoEnable,
   output logic [TRIM_W-1:0] rcTrim,
   // power control
   input wire logic powerUpCmd,
   input wire logic shutdownExit,
   input wire logic sleepReq,
   input wire logic readyReq,
   output logic sleepState,
   output logic dutyWindowActive,
   // wake actions
   output logic rxStart,
   output logic txStart,
   output logic batteryStart,
   // interrupt
   output logic interrupt_request_n
);
   // ---------------------------------------------------------
   // checks
   // ---------------------------------------------------------
   if (TRIM_W < 2 || RECAL_W < `CAL_BASE_SHIFT + 8)
   begin : g_bad
      $error("unsupported trim or recal width");
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // ---------------------------------------------------------
   // registers
   // ---------------------------------------------------------
   wake_timer_pkg::wake_cfg_t cfg_r;
   wake_timer_pkg::exp_state_t expState_r;
   wake_timer_pkg::power_state_t ps_r;
   wake_timer_pkg::cal_state_t cal_r;
   logic [15:0] periodMultiplier_r;
   logic [7:0] dutyCycleCount_r, intEnable_r, intStatus_r, intStatus_nxt;
   logic clkSel_r;
   logic [33:0] preCnt_r;
   logic [15:0] multCnt_r;
   logic [7:0] dutyCnt_r;
   logic [RECAL_W-1:0] recalCnt_r;
   logic [5:0] measRc_r;
   logic [15:0] measXo_r;
   logic [TRIM_W-1:0] rcTrim_r;
   logic [7:0] rdata_r;
   logic rxStart_r, txStart_r, batteryStart_r;
   logic tick, preHit, wakeExpire, windowEnd, recalDue, calStart, calDone;
   logic [7:0] intSet, intClr;
   // shift held in 6 bits so an exponent of 31 does not wrap
   function automatic logic [33:0] preLimit(input logic [4:0] r);
      preLimit = (`PRE_ONE << (6'(`PERIOD_SCALE_SHIFT) + {1'b0, r})) -
         `PRE_ONE;
   endfunction
   function automatic logic isLast(input logic [15:0] cnt,
                                   input logic [15:0] n);
      isLast = (n != 16'h0000) && (cnt == n - 16'h0001);
   endfunction
   // ---------------------------------------------------------
   // register writes
   // ---------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cfg_r <= wake_timer_pkg::wake_cfg_t'(`REG_RESET_VAL);
         expState_r <= wake_timer_pkg::exp_state_t'(`REG_RESET_VAL);
         periodMultiplier_r <= {`REG_RESET_VAL, `REG_RESET_VAL};
         dutyCycleCount_r <= `REG_RESET_VAL;
         intEnable_r <= `REG_RESET_VAL;
         clkSel_r <= 1'b0;
      end
      else if (wrEn)
      begin
         case (addr)
            `REG_CONFIG:
               cfg_r <= wake_timer_pkg::wake_cfg_t'(wdata);
            `REG_MULT_HI:
               periodMultiplier_r[15:8] <= wdata; // [RL11]
            `REG_MULT_LO:
               periodMultiplier_r[7:0] <= wdata; // [RL11]
            `REG_EXP_STATE:
               expState_r <= wake_timer_pkg::exp_state_t'(wdata); // [RL12]
            `REG_DUTY_COUNT:
               dutyCycleCount_r <= wdata; // [RL14]
            `REG_INT_ENABLE:
               intEnable_r <= wdata;
            `REG_CLK_CFG:
               clkSel_r <= wdata[`CLK_SEL_BIT];
            default:
               clkSel_r <= clkSel_r;
         endcase
      end
   end
   // ---------------------------------------------------------
   // register reads
   // ---------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         rdata_r <= `READ_NONE;
      else if (rdEn)
      begin
         case (addr)
            `REG_CONFIG: rdata_r <= cfg_r;
            `REG_MULT_HI: rdata_r <= periodMultiplier_r[15:8];
            `REG_MULT_LO: rdata_r <= periodMultiplier_r[7:0];
            `REG_EXP_STATE: rdata_r <= {2'h0, expState_r[5:0]};
            `REG_DUTY_COUNT: rdata_r <= dutyCycleCount_r;
            `REG_INT_STATUS: rdata_r <= intStatus_r; // [RL4]
            `REG_INT_ENABLE: rdata_r <= intEnable_r;
            `REG_CLK_CFG: rdata_r <= {7'h00, clkSel_r};
            `REG_DEV_STATE: rdata_r <= {1'b0, cal_r, ps_r};
            default: rdata_r <= `READ_NONE;
         endcase
      end
      else
         rdata_r <= `READ_NONE;
   end
   // ---------------------------------------------------------
   // period counter
   // ---------------------------------------------------------
   assign tick = clkSel_r ? xtalTick : rcTick; // [RL5]
   // prescaler gives the 4 * 2^exponent step
   assign preHit = tick &&
      (preCnt_r == preLimit(expState_r.periodExponent)); // [RL1]
   assign wakeExpire = preHit &&
      isLast(multCnt_r, periodMultiplier_r); // [RL1]
   // counting ignores power state so sleep does not stop it
   always_ff @(posedge clk)
   begin
      if (!rst_n || !cfg_r.timerRunEnable)
      begin
         preCnt_r <= 34'h0;
         multCnt_r <= 16'h0000;
      end
      else if (preHit)
      begin
         preCnt_r <= 34'h0; // [RL2]
         multCnt_r <= wakeExpire ? 16'h0000 : multCnt_r + 16'h0001; // [RL16]
      end
      else if (tick)
         preCnt_r <= preCnt_r + `PRE_ONE; // [RL2]
   end
   a_expire_reload: assert property (wakeExpire |=> // [RL16]
      multCnt_r == 16'h0000 && preCnt_r == 34'h0)
      else $error("counter did not reload on expiry");
   a_disabled_hold: assert property (!cfg_r.timerRunEnable |=> // [RL2]
      !wakeExpire && multCnt_r == 16'h0000)
      else $error("timer counted while disabled");
   a_period_figure: assert property (wakeExpire |-> // [RL1]
      multCnt_r == periodMultiplier_r - 16'h0001 &&
      preCnt_r == preLimit(expState_r.periodExponent))
      else $error("expiry at the wrong count");
   // ---------------------------------------------------------
   // power state and duty window
   // ---------------------------------------------------------
   // window reuses the period prescaler, aligned by the reload
   assign windowEnd = (ps_r == wake_timer_pkg::PS_ACTIVE) &&
      (!cfg_r.timerRunEnable || (preHit &&
      isLast({8'h00, dutyCnt_r}, {8'h00, dutyCycleCount_r}))); // [RL15]
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         ps_r <= wake_timer_pkg::PS_READY;
      else
         case (ps_r)
            wake_timer_pkg::PS_READY,
            wake_timer_pkg::PS_SLEEP:
            begin
               if (wakeExpire && cfg_r.dutyCycleModeSelect != `DC_OFF &&
                   dutyCycleCount_r != 8'h00)
                  ps_r <= wake_timer_pkg::PS_ACTIVE; // [RL9]
               else if (wakeExpire)
                  ps_r <= expState_r.afterExpiryStateSelect ?
                     wake_timer_pkg::PS_SLEEP :
                     wake_timer_pkg::PS_READY; // [RL10]
               else if (sleepReq)
                  ps_r <= wake_timer_pkg::PS_SLEEP;
               else if (readyReq)
                  ps_r <= wake_timer_pkg::PS_READY;
            end
            wake_timer_pkg::PS_ACTIVE:
               if (windowEnd)
                  ps_r <= expState_r.afterExpiryStateSelect ?
                     wake_timer_pkg::PS_SLEEP :
                     wake_timer_pkg::PS_READY; // [RL10]
            default:
               ps_r <= wake_timer_pkg::PS_READY;
         endcase
   end
   always_ff @(posedge clk)
   begin
      if (!rst_n || ps_r != wake_timer_pkg::PS_ACTIVE)
         dutyCnt_r <= 8'h00;
      else if (preHit)
         dutyCnt_r <= dutyCnt_r + 8'h01; // [RL15]
   end
   a_sleep_after: assert property (wakeExpire && // [RL10]
      cfg_r.dutyCycleModeSelect == `DC_OFF &&
      expState_r.afterExpiryStateSelect |=>
      ps_r == wake_timer_pkg::PS_SLEEP)
      else $error("no sleep after expiry");
   // ---------------------------------------------------------
   // wake actions
   // ---------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rxStart_r <= 1'b0;
         txStart_r <= 1'b0;
         batteryStart_r <= 1'b0;
      end
      else
      begin
         rxStart_r <= wakeExpire &&
            cfg_r.dutyCycleModeSelect == `DC_RX; // [RL9]
         txStart_r <= wakeExpire &&
            cfg_r.dutyCycleModeSelect == `DC_TX; // [RL9]
         batteryStart_r <= wakeExpire &&
            cfg_r.batteryCheckOnInterval; // [RL13]
      end
   end
   a_rx_start: assert property (wakeExpire && // [RL9]
      cfg_r.dutyCycleModeSelect == `DC_RX |=> rxStart && !txStart)
      else $error("receive start missing");
   a_battery_check: assert property ($rose(batteryStart) |-> // [RL13]
      $past(wakeExpire) && $past(cfg_r.batteryCheckOnInterval))
      else $error("battery check without interval");
   // ---------------------------------------------------------
   // rc calibration
   // ---------------------------------------------------------
   assign recalDue = cfg_r.calEnable && rcTick &&
      (recalCnt_r == RECAL_W'((1 << (`CAL_BASE_SHIFT +
      cfg_r.rcRecalInterval)) - 1)); // [RL7]
   assign calStart = powerUpCmd || shutdownExit || recalDue; // [RL6]
   assign calDone = (cal_r == wake_timer_pkg::CAL_ADJUST);
   always_ff @(posedge clk)
   begin
      if (!rst_n || !cfg_r.calEnable || recalDue)
         recalCnt_r <= '0;
      else if (rcTick)
         recalCnt_r <= recalCnt_r + RECAL_W'(1); // [RL7]
   end
   // a trigger during a running calibration is dropped, not queued
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         cal_r <= wake_timer_pkg::CAL_IDLE;
      else
         case (cal_r)
            wake_timer_pkg::CAL_IDLE:
               if (calStart)
                  cal_r <= wake_timer_pkg::CAL_XO_START; // [RL6]
            wake_timer_pkg::CAL_XO_START:
               if (xoReady)
                  cal_r <= wake_timer_pkg::CAL_MEASURE; // [RL8]
            wake_timer_pkg::CAL_MEASURE:
               if (rcTick && measRc_r == 6'(`CAL_RC_TICKS))
                  cal_r <= wake_timer_pkg::CAL_ADJUST; // [RL8]
            wake_timer_pkg::CAL_ADJUST:
               cal_r <= wake_timer_pkg::CAL_IDLE;
            default:
               cal_r <= wake_timer_pkg::CAL_IDLE;
         endcase
   end
   // window opens on the first rc tick so it spans whole rc periods
   always_ff @(posedge clk)
   begin
      if (!rst_n || cal_r != wake_timer_pkg::CAL_MEASURE)
      begin
         measRc_r <= 6'h00;
         measXo_r <= 16'h0000;
      end
      else
      begin
         if (rcTick)
            measRc_r <= measRc_r + 6'h01;
         if (xoTick && measRc_r != 6'h00 && measXo_r != 16'hffff)
            measXo_r <= measXo_r + 16'h0001; // [RL8]
      end
   end
   // more crystal ticks per window means the rc runs slow
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         rcTrim_r <= TRIM_W'(1 << (TRIM_W - 1));
      else if (calDone && measXo_r > 16'(`CAL_XO_EXPECT) &&
               rcTrim_r != '1)
         rcTrim_r <= rcTrim_r + TRIM_W'(1); // [RL8]
      else if (calDone && measXo_r < 16'(`CAL_XO_EXPECT) &&
               rcTrim_r != '0)
         rcTrim_r <= rcTrim_r - TRIM_W'(1); // [RL8]
   end
   a_cal_trigger: assert property (powerUpCmd && // [RL6]
      cal_r == wake_timer_pkg::CAL_IDLE |=>
      cal_r == wake_timer_pkg::CAL_XO_START && xoEnable)
      else $error("power-up did not start calibration");
   a_cal_xo_on: assert property (cal_r == wake_timer_pkg::CAL_MEASURE // [RL8]
      |-> xoEnable && $past(xoEnable))
      else $error("crystal off during measurement");
   a_recal_gate: assert property (!cfg_r.calEnable && // [RL7]
      !powerUpCmd && !shutdownExit &&
      cal_r == wake_timer_pkg::CAL_IDLE |=>
      cal_r == wake_timer_pkg::CAL_IDLE)
      else $error("recalibration while disabled");
   // ---------------------------------------------------------
   // interrupt status
   // ---------------------------------------------------------
   always_comb
   begin
      intSet = 8'h00;
      intSet[`INT_WAKE_BIT] = wakeExpire;
      intSet[`INT_CAL_BIT] = calDone;
      intClr = (wrEn && addr == `REG_INT_CLEAR) ? wdata : 8'h00;
      // set beats a clear in the same cycle
      intStatus_nxt = (intStatus_r & ~intClr) | intSet;
   end
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         intStatus_r <= `REG_RESET_VAL;
      else
         intStatus_r <= intStatus_nxt;
   end
   a_set_wins: assert property (wakeExpire |=> // [RL3]
      intStatus_r[`INT_WAKE_BIT])
      else $error("expiry flag lost");
   a_irq_gating: assert property (wakeExpire && // [RL3]
      intEnable_r[`INT_WAKE_BIT] |=> !interrupt_request_n)
      else $error("interrupt missing after enabled expiry");
   a_irq_masked: assert property (intEnable_r == 8'h00 |-> // [RL3]
      interrupt_request_n)
      else $error("interrupt while masked");
   // ---------------------------------------------------------
   // outputs
   // ---------------------------------------------------------
   assign interrupt_request_n = !(|(intStatus_r & intEnable_r)); // [RL3]
   assign rdata = rdata_r;
   assign xoEnable = (cal_r == wake_timer_pkg::CAL_XO_START) ||
      (cal_r == wake_timer_pkg::CAL_MEASURE); // [RL8]
   assign rcTrim = rcTrim_r;
   assign sleepState = (ps_r == wake_timer_pkg::PS_SLEEP);
   assign dutyWindowActive = (ps_r == wake_timer_pkg::PS_ACTIVE);
   assign rxStart = rxStart_r;
   assign txStart = txStart_r;
   assign batteryStart = batteryStart_r;
endmodule
`default_nettype wire

// file: testbench/clock_source_model.sv
/*
 far-side clock sources: rc and 32 kHz crystal tick strobes, plus the
 30 MHz crystal that starts on request. assumes one bench clock.
*/
`timescale 1ns/1ps
`default_nettype none

module clock_source_model
#(
   parameter int RC_DIV = 4,
   parameter int XTAL_DIV = 6,
   parameter int XO_START = 10
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // crystal request
   input wire logic xoEnable,
   // tick strobes
   output logic rcTick,
   output logic xtalTick,
   output logic xoTick,
   output logic xoReady
);
   int rcCnt = 0;
   int xtCnt = 0;
   int xoCnt = 0;
   // -----------------------------------------------------
   // free-running 32 kHz sources
   // -----------------------------------------------------
   always @(posedge clk)
   begin
      rcCnt <= (rcCnt == RC_DIV - 1) ? 0 : rcCnt + 1;
      xtCnt <= (xtCnt == XTAL_DIV - 1) ? 0 : xtCnt + 1;
   end
   assign rcTick = (rcCnt == 0);
   assign xtalTick = (xtCnt == 0);
   // -----------------------------------------------------
   // main crystal: slow start, stops when released
   // -----------------------------------------------------
   always @(posedge clk)
   begin
      if (!rst_n || !xoEnable)
         xoCnt <= 0;
      else if (xoCnt < XO_START)
         xoCnt <= xoCnt + 1;
   end
   assign xoReady = (xoCnt == XO_START);
   // one pulse per cycle only while running, none before start
   assign xoTick = xoReady;
endmodule
`default_nettype wire

// file: testbench/testbench.sv
/*
 self-checking bench for the periodic wake timer.
 assumes the clock source model on the far side, rc tick every 4 clocks.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wake_timer_defines.svh"
`define CHECK(got, exp) begin checked++; if ((got) !== (exp)) begin \
   numErrors++; $display("[FAIL] %0t got %h exp %h", $time, got, exp); \
   end end

module testbench;
   logic clk = 1'b0;
   logic rstN = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wrEn = 1'b0;
   logic rdEn = 1'b0;
   logic [7:0] rdata;
   logic rcTick, xtalTick, xoTick, xoReady, xoEnable;
   logic [6:0] rcTrim;
   logic powerUpCmd = 1'b0;
   logic shutdownExit = 1'b0;
   logic sleepReq = 1'b0;
   logic readyReq = 1'b0;
   logic sleepState, dutyWindowActive, rxStart, txStart, batteryStart;
   logic interrupt_request_n;
   int numErrors = 0;
   int checked = 0;
   int cyc = 0;
   int lastStamp = 0;
   int periodCycles = 0;
   int pulseCnt = 0;
   int rxCnt = 0;
   int txCnt = 0;
   int batCnt = 0;
   int winRun = 0;
   int winLen = 0;
   logic xoSeen = 1'b0;
   logic [7:0] d;
   int r0, t0, b0;

   initial
   begin
      forever #2.5 clk = ~clk;
   end

   periodic_wakeup_timer dut_u (.clk(clk), .rst_n(rstN), .addr(addr),
      .wdata(wdata), .wrEn(wrEn), .rdEn(rdEn), .rdata(rdata),
      .rcTick(rcTick), .xtalTick(xtalTick), .xoTick(xoTick),
      .xoReady(xoReady), .xoEnable(xoEnable), .rcTrim(rcTrim),
      .powerUpCmd(powerUpCmd), .shutdownExit(shutdownExit),
      .sleepReq(sleepReq), .readyReq(readyReq), .sleepState(sleepState),
      .dutyWindowActive(dutyWindowActive), .rxStart(rxStart),
      .txStart(txStart), .batteryStart(batteryStart),
      .interrupt_request_n(interrupt_request_n));

   clock_source_model src_u (.clk(clk), .rst_n(rstN), .xoEnable(xoEnable),
      .rcTick(rcTick), .xtalTick(xtalTick), .xoTick(xoTick),
      .xoReady(xoReady));

   // -----------------------------------------------------
   // monitor: wake pulse spacing and window length
   // -----------------------------------------------------
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (xoEnable === 1'b1)
         xoSeen <= 1'b1;
      if (rxStart === 1'b1 || txStart === 1'b1 || batteryStart === 1'b1)
      begin
         pulseCnt <= pulseCnt + 1;
         periodCycles <= cyc - lastStamp;
         lastStamp <= cyc;
      end
      if (rxStart === 1'b1)
         rxCnt <= rxCnt + 1;
      if (txStart === 1'b1)
         txCnt <= txCnt + 1;
      if (batteryStart === 1'b1)
         batCnt <= batCnt + 1;
      winRun <= (dutyWindowActive === 1'b1) ? winRun + 1 : 0;
      if (dutyWindowActive !== 1'b1 && winRun != 0)
         winLen <= winRun;
   end

   // -----------------------------------------------------
   // register port and helpers
   // -----------------------------------------------------
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      wrEn <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wrEn <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk);
      rdEn <= 1'b1;
      addr <= a;
      @(posedge clk);
      rdEn <= 1'b0;
      #1 v = rdata;
   endtask

   task automatic wait_pulses(input int n);
      int start;
      int i;
      start = pulseCnt;
      for (i = 0; i < 3000 && pulseCnt - start < n; i++)
         @(posedge clk);
      if (pulseCnt - start < n)
      begin
         numErrors++;
         $display("[FAIL] %0t no wake pulse", $time);
         report_and_stop();
      end
      #1;
   endtask

   task automatic wait_cal();
      int i;
      d = 8'h00;
      for (i = 0; i < 500 && d[`INT_CAL_BIT] !== 1'b1; i++)
         rd(`REG_INT_STATUS, d);
      `CHECK(d[`INT_CAL_BIT], 1'b1)
      if (d[`INT_CAL_BIT] !== 1'b1)
         report_and_stop();
   endtask

   task automatic report_and_stop();
      $display("errors %0d checks %0d", numErrors, checked);
      if (numErrors == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // -----------------------------------------------------
   // main sequence
   // -----------------------------------------------------
   initial
   begin
      repeat (4) @(posedge clk);
      rstN <= 1'b1;
      @(posedge clk);
      #1;
      `CHECK(interrupt_request_n, 1'b1)
      `CHECK(rcTrim, 7'h40)
      for (int a = 0; a < 8; a++)
      begin
         rd(4'(a), d);
         `CHECK(d, 8'h00)
      end
      rd(4'ha, d);
      `CHECK(d, 8'h00)
      rd(`REG_DEV_STATE, d);
      `CHECK(d, 8'h09)
      // byte-wide fields held apart
      wr(`REG_MULT_HI, 8'h5a);
      wr(`REG_MULT_LO, 8'ha5);
      wr(`REG_EXP_STATE, 8'hff);
      wr(`REG_DUTY_COUNT, 8'h3c);
      wr(`REG_INT_STATUS, 8'hff);
      rd(`REG_MULT_HI, d);
      `CHECK(d, 8'h5a)
      rd(`REG_MULT_LO, d);
      `CHECK(d, 8'ha5)
      rd(`REG_EXP_STATE, d);
      `CHECK(d, 8'h3f)
      rd(`REG_DUTY_COUNT, d);
      `CHECK(d, 8'h3c)
      rd(`REG_INT_STATUS, d);
      `CHECK(d, 8'h00)
      // calibration: rc fast against the crystal, trim steps down
      @(posedge clk) powerUpCmd <= 1'b1;
      @(posedge clk) powerUpCmd <= 1'b0;
      wait_cal();
      `CHECK(xoSeen, 1'b1)
      `CHECK(rcTrim, 7'h3f)
      wr(`REG_INT_CLEAR, 8'h02);
      rd(`REG_INT_STATUS, d);
      `CHECK(d, 8'h00)
      @(posedge clk) shutdownExit <= 1'b1;
      @(posedge clk) shutdownExit <= 1'b0;
      wait_cal();
      `CHECK(rcTrim, 7'h3e)
      wr(`REG_INT_CLEAR, 8'h02);
      // receive mode from sleep, ready afterwards: 4 ticks of 4 clocks
      wr(`REG_MULT_HI, 8'h00);
      wr(`REG_MULT_LO, 8'h01);
      wr(`REG_EXP_STATE, 8'h00);
      wr(`REG_DUTY_COUNT, 8'h00);
      wr(`REG_INT_ENABLE, 8'h01);
      @(posedge clk) sleepReq <= 1'b1;
      @(posedge clk) sleepReq <= 1'b0;
      @(posedge clk) #1;
      `CHECK(sleepState, 1'b1)
      r0 = rxCnt;
      b0 = batCnt;
      wr(`REG_CONFIG, 8'h07);
      wait_pulses(1);
      `CHECK(rxCnt - r0, 1)
      `CHECK(batCnt - b0, 1)
      `CHECK(interrupt_request_n, 1'b0)
      `CHECK(sleepState, 1'b0)
      wait_pulses(1);
      `CHECK(periodCycles, 16)
      rd(`REG_DEV_STATE, d);
      `CHECK(d[2:0], 3'h1)
      rd(`REG_INT_STATUS, d);
      `CHECK(d[`INT_WAKE_BIT], 1'b1)
      // mode none, sleep after, M=2 R=1: 16 ticks
      wr(`REG_CONFIG, 8'h00);
      wr(`REG_MULT_LO, 8'h02);
      wr(`REG_EXP_STATE, 8'h21);
      r0 = rxCnt;
      t0 = txCnt;
      wr(`REG_CONFIG, 8'h03);
      wait_pulses(2);
      `CHECK(periodCycles, 64)
      `CHECK(sleepState, 1'b1)
      `CHECK(rxCnt - r0, 0)
      `CHECK(txCnt - t0, 0)
      // external crystal: tick every 6 clocks
      wr(`REG_CONFIG, 8'h00);
      wr(`REG_MULT_LO, 8'h01);
      wr(`REG_EXP_STATE, 8'h00);
      wr(`REG_CLK_CFG, 8'h01);
      wr(`REG_CONFIG, 8'h03);
      wait_pulses(2);
      `CHECK(periodCycles, 24)
      wr(`REG_CONFIG, 8'h00);
      wr(`REG_CLK_CFG, 8'h00);
      wr(`REG_INT_CLEAR, 8'h03);
      rd(`REG_INT_STATUS, d);
      `CHECK(d, 8'h00)
      `CHECK(interrupt_request_n, 1'b1)
      // transmit mode, window of one count, sleep after, irq masked
      wr(`REG_INT_ENABLE, 8'h00);
      wr(`REG_MULT_LO, 8'h02);
      wr(`REG_EXP_STATE, 8'h20);
      wr(`REG_DUTY_COUNT, 8'h01);
      t0 = txCnt;
      wr(`REG_CONFIG, 8'h09);
      wait_pulses(1);
      `CHECK(txCnt - t0, 1)
      `CHECK(dutyWindowActive, 1'b1)
      `CHECK(interrupt_request_n, 1'b1)
      for (int i = 0; i < 100 && dutyWindowActive === 1'b1; i++)
         @(posedge clk) #1;
      `CHECK(dutyWindowActive, 1'b0)
      @(posedge clk) #1;
      `CHECK(winLen, 16)
      `CHECK(sleepState, 1'b1)
      wr(`REG_INT_ENABLE, 8'h01);
      #1;
      `CHECK(interrupt_request_n, 1'b0)
      wr(`REG_CONFIG, 8'h00);
      wr(`REG_INT_CLEAR, 8'h01);
      #1;
      `CHECK(interrupt_request_n, 1'b1)
      @(posedge clk) readyReq <= 1'b1;
      @(posedge clk) readyReq <= 1'b0;
      @(posedge clk) #1;
      `CHECK(sleepState, 1'b0)
      // periodic recalibration: shortest interval, 2^14 rc ticks
      wr(`REG_CONFIG, 8'h10);
      for (int i = 0; i < 70000 && xoEnable !== 1'b1; i++)
         @(posedge clk) #1;
      `CHECK(xoEnable, 1'b1)
      wait_cal();
      `CHECK(rcTrim, 7'h3d)
      report_and_stop();
   end
endmodule
`default_nettype wire
